/* tpm_top.sv */
// tach period measure: counts clocks between programmable starting edges of the
// tachometer pin and hands the count to the input stream, delayed to line up with adc data
// assumes the stream assembler is on clk, raises smp_valid once per a/d sample after
// its trigger, and holds acq_run high while the input operation runs
`timescale 1ns/1ps

module tpm_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // conditioned tachometer pin, asynchronous
  input  wire logic        tach_in,
  // stream assembler side
  input  wire logic        acq_run,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  output logic             tach_valid,
  input  wire logic        tach_ready,
  output logic [31:0]      tach_data
);

  ////////////////////////////////////////////////////////////////////////
  // state of the whole block

  typedef struct packed {
    logic [1:0]                       tsync;
    logic                             tprev;
    tpm_pkg::tpm_st_t                 st;
    logic [tpm_pkg::TICK_W-1:0]       div;
    logic [31:0]                      cnt;
    logic [31:0]                      latch;
    logic                             fresh;
    logic [tpm_pkg::DELAY_W-1:0]      seen;
    logic [tpm_pkg::CREDIT_W-1:0]     credit;
    logic                             run_d;
    logic [31:0]                      ctrl;
    logic [31:0]                      chmask;
    logic [tpm_pkg::DELAY_W-1:0]      dly;
    logic                             awready;
    logic                             wready;
    logic                             have_aw;
    logic                             have_w;
    logic [tpm_pkg::ADDR_W-1:0]       awaddr;
    logic [31:0]                      wdata;
    logic [3:0]                       wstrb;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
  } tpm_state_t;

  tpm_state_t  s_r;
  tpm_state_t  s_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_i_n;

  // fifo hookup
  logic        f_push;
  logic [31:0] f_data;
  logic        f_in_ready;
  logic        f_rd_en;
  logic        f_pop;
  logic        f_flush;

  // combinational helpers
  logic        active;
  logic        tick;
  logic        edge_rise;
  logic        edge_fall;
  logic        start_edge;
  logic        sample;
  logic        stale_en;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_i_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // edge detect and sample qualification; tsync[0] feeds only tsync[1]
  assign active     = acq_run;
  assign tick       = (s_r.div == '0);
  assign edge_rise  = s_r.tsync[1] & ~s_r.tprev;
  assign edge_fall  = ~s_r.tsync[1] & s_r.tprev;
  assign start_edge = s_r.ctrl[tpm_pkg::CTRL_FALL_BIT] ? edge_fall : edge_rise;
  assign stale_en   = s_r.ctrl[tpm_pkg::CTRL_STALE_BIT];
  // samples are only offered after the stream's trigger, so tach follows it
  assign sample     = smp_valid & f_in_ready & active;

  // word pushed per sample: msb carries staleness, low bits the latched count
  assign f_push  = sample & s_r.chmask[tpm_pkg::CHMASK_TACH_BIT];
  assign f_data  = {stale_en & ~s_r.fresh, s_r.latch[30:0]};
  assign f_rd_en = (s_r.credit != '0);
  // stopping drops queued words so a restart does not replay old counts
  assign f_flush = ~active;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [31:0] rd_val;
    logic [31:0] wmerge;
    logic [31:0] wold;
    logic        wr_ok;
    logic        rd_ok;
    rd_val = 32'h0000_0000;
    wmerge = 32'h0000_0000;
    wold   = 32'h0000_0000;
    wr_ok  = 1'b0;
    rd_ok  = 1'b0;
    s_nxt  = s_r;

    // pin synchroniser
    s_nxt.tsync = {s_r.tsync[0], tach_in};
    s_nxt.tprev = s_r.tsync[1];
    s_nxt.run_d = active;

    // count tick divider; at or below the count rate it ticks every clock
    if (s_r.div == tpm_pkg::TICK_W'(tpm_pkg::TICK_DIV - 1))
      s_nxt.div = '0;
    else
      s_nxt.div = s_r.div + 1'b1;

    // ------------------------------------------------------------------
    // period measurement
    if (!active)
    begin
      s_nxt.st     = tpm_pkg::TPM_IDLE;
      s_nxt.cnt    = 32'h0000_0000;
      s_nxt.latch  = 32'h0000_0000;
      s_nxt.fresh  = 1'b0;
      s_nxt.seen   = '0;
      s_nxt.credit = '0;
    end
    else
    begin
      unique case (s_r.st)
        tpm_pkg::TPM_IDLE:
        begin
          // first starting edge opens the first period
          if (start_edge)
          begin
            s_nxt.st  = tpm_pkg::TPM_COUNT;
            s_nxt.cnt = 32'h0000_0001;
          end
        end
        tpm_pkg::TPM_COUNT:
        begin
          if (start_edge)
          begin
            // n ticks between edges latch as n+1
            s_nxt.latch = s_r.cnt + 32'h0000_0001;
            s_nxt.cnt   = 32'h0000_0001;
          end
          else if (tick && (s_r.cnt != 32'h7FFF_FFFF))
            s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
      endcase

      // fresh flag: a latch in the same cycle as a sample wins over the clear
      if (f_push)
        s_nxt.fresh = 1'b0;
      if ((s_r.st == tpm_pkg::TPM_COUNT) && start_edge)
        s_nxt.fresh = 1'b1;

      // delay line: the first dly pushes only prime it, later ones release a word
      if (f_push)
      begin
        if (s_r.seen < s_r.dly)
          s_nxt.seen = s_r.seen + 1'b1;
        else
          s_nxt.credit = s_r.credit + 1'b1;
      end
      if (f_pop)
        s_nxt.credit = s_nxt.credit - 1'b1;
    end

    // ------------------------------------------------------------------
    // axi write: address and data caught in either order
    if (s_r.awready && s_axi_awvalid)
    begin
      s_nxt.awaddr  = s_axi_awaddr;
      s_nxt.have_aw = 1'b1;
      s_nxt.awready = 1'b0;
    end
    if (s_r.wready && s_axi_wvalid)
    begin
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
      s_nxt.have_w = 1'b1;
      s_nxt.wready = 1'b0;
    end
    if (s_r.have_aw && s_r.have_w && !s_r.bvalid)
    begin
      wr_ok = 1'b1;
      unique case (s_r.awaddr)
        tpm_pkg::REG_CTRL:   wold = s_r.ctrl;
        tpm_pkg::REG_CHMASK: wold = s_r.chmask;
        tpm_pkg::REG_DELAY:  wold = {27'h0, s_r.dly};
        tpm_pkg::REG_COUNT:  wold = 32'h0000_0000;
        tpm_pkg::REG_STATUS: wold = 32'h0000_0000;
        default:             wr_ok = 1'b0;
      endcase
      for (int b = 0; b < 4; b++)
        wmerge[b*8 +: 8] = s_r.wstrb[b] ? s_r.wdata[b*8 +: 8] : wold[b*8 +: 8];
      if (s_r.awaddr == tpm_pkg::REG_CTRL)
        s_nxt.ctrl = wmerge & (32'h0000_0001 << tpm_pkg::CTRL_FALL_BIT
                               | 32'h0000_0001 << tpm_pkg::CTRL_STALE_BIT);
      if (s_r.awaddr == tpm_pkg::REG_CHMASK)
        s_nxt.chmask = wmerge;
      if (s_r.awaddr == tpm_pkg::REG_DELAY)
        s_nxt.dly = wmerge[tpm_pkg::DELAY_W-1:0];
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = wr_ok ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
      s_nxt.have_aw = 1'b0;
      s_nxt.have_w  = 1'b0;
    end
    // reopen both channels once the response is taken
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // ------------------------------------------------------------------
    // axi read: one beat, answered the cycle after the address is taken
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      tpm_pkg::REG_CTRL:   rd_val = s_r.ctrl;
      tpm_pkg::REG_CHMASK: rd_val = s_r.chmask;
      tpm_pkg::REG_DELAY:  rd_val = {27'h0, s_r.dly};
      tpm_pkg::REG_COUNT:  rd_val = s_r.latch;
      tpm_pkg::REG_STATUS: rd_val = {29'h0, f_in_ready,
                                     s_r.st == tpm_pkg::TPM_COUNT, s_r.fresh};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
    if (s_r.arready && s_axi_arvalid)
    begin
      s_nxt.rdata   = rd_val;
      s_nxt.rresp   = rd_ok ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
      s_nxt.rvalid  = 1'b1;
      s_nxt.arready = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset clears the measurement and loads register defaults
  always_ff @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      s_r         <= '0;
      s_r.st      <= tpm_pkg::TPM_IDLE;
      s_r.ctrl    <= tpm_pkg::CTRL_RST;
      s_r.chmask  <= tpm_pkg::CHMASK_RST;
      s_r.dly     <= tpm_pkg::DELAY_RST;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign smp_ready     = f_in_ready;

  ////////////////////////////////////////////////////////////////////////
  // sample fifo doubles as the group-delay pipeline; a stalled reader
  // fills it and then holds smp_ready low toward the assembler
  tpm_fifo #(
    .W (tpm_pkg::DATA_W),
    .D (tpm_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_i_n),
    .flush     (f_flush),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (f_data),
    .rd_en     (f_rd_en),
    .pop       (f_pop),
    .out_valid (tach_valid),
    .out_ready (tach_ready),
    .out_data  (tach_data)
  );

endmodule : tpm_top

/* tpm_fifo.sv */
// tach period measure: shared constants package and the sample fifo
// assumes one clock domain and an active-low reset already synchronised by the caller
package tpm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the axi4-lite slave
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_CHMASK      = 8'h04;
  localparam logic [7:0]  REG_DELAY       = 8'h08;
  localparam logic [7:0]  REG_COUNT       = 8'h0C;
  localparam logic [7:0]  REG_STATUS      = 8'h10;
  localparam int          ADDR_W          = 8;

  // control fields and reset values
  localparam int          CTRL_FALL_BIT   = 1;
  localparam int          CTRL_STALE_BIT  = 2;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0004;
  localparam int          CHMASK_TACH_BIT = 8;
  localparam logic [31:0] CHMASK_RST      = 32'h0000_0000;
  localparam int          DELAY_W         = 5;
  localparam logic [4:0]  DELAY_RST       = 5'h06;

  // status fields
  localparam int          STAT_FRESH_BIT  = 0;
  localparam int          STAT_MEAS_BIT   = 1;
  localparam int          STAT_READY_BIT  = 2;

  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // data path and timing
  localparam int          DATA_W          = 32;
  localparam int          FIFO_D          = 32;
  localparam int          CREDIT_W        = 6;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          CNT_HZ          = 12_000_000;
  localparam int          CNT_RES_NS      = 83;
  // clocks per count tick; never below one clock
  localparam int          TICK_DIV        = (CLK_HZ >= CNT_HZ) ? (CLK_HZ / CNT_HZ) : 1;
  localparam int          TICK_W          = 4;

  typedef enum logic [1:0]
  {
    TPM_IDLE  = 2'b00,
    TPM_COUNT = 2'b01
  } tpm_st_t;

endpackage : tpm_pkg

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// fifo with registered read data; rd_en lets the owner hold words back
module tpm_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  input  wire logic         rd_en,
  output logic              pop,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                full;
    logic                ovalid;
    logic [W-1:0]        odata;
  } tpm_fifo_t;

  tpm_fifo_t s_r;
  tpm_fifo_t s_nxt;
  logic      push;

  // full comes from a register so in_ready is a clean flop output
  assign in_ready  = ~s_r.full;
  assign out_valid = s_r.ovalid;
  assign out_data  = s_r.odata;
  assign push      = in_valid & ~s_r.full;
  assign pop       = rd_en & (s_r.cnt != '0) & (~s_r.ovalid | out_ready);

  // next state: drain output stage, refill it, then store the pushed word
  always_comb
  begin
    s_nxt = s_r;
    if (s_r.ovalid && out_ready)
      s_nxt.ovalid = 1'b0;
    if (pop)
    begin
      s_nxt.odata  = s_r.mem[s_r.rp];
      s_nxt.ovalid = 1'b1;
      s_nxt.rp     = s_r.rp + 1'b1;
    end
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    s_nxt.cnt  = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    s_nxt.full = (s_nxt.cnt == (AW + 1)'(D));
    if (flush)
    begin
      s_nxt.wp     = '0;
      s_nxt.rp     = '0;
      s_nxt.cnt    = '0;
      s_nxt.full   = 1'b0;
      s_nxt.ovalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule : tpm_fifo

/* tpm_assertions.sv */
// checker for tach period measure: register bus and stream handshakes at the top ports
// assumes one clock and the raw active-low reset; bound into tpm_top below
`timescale 1ns/1ps

module tpm_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        acq_run,
  input wire logic        tach_valid,
  input wire logic        tach_ready,
  input wire logic [31:0] tach_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // remember whether the write in flight went past REG_STATUS; aw is not retaken before b
  logic bad_aw_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) bad_aw_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) bad_aw_r <= s_axi_awaddr > tpm_pkg::REG_STATUS;

  ////////////////////////////////////////////////////////////////////////
  // bus steps and their answers
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_code;
    s_axi_bvalid |-> s_axi_bresp == (bad_aw_r ? tpm_pkg::RESP_SLVERR : tpm_pkg::RESP_OKAY);
  endproperty
  a_b_code: assert property (p_b_code) else $error("write response code wrong");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("second write accepted early");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  property p_rd_bad;
    s_rd_take ##0 (s_axi_araddr > tpm_pkg::REG_STATUS) |=> s_axi_rresp == tpm_pkg::RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("hole read not refused");
  property p_t_hold; tach_valid && !tach_ready && acq_run |=> tach_valid && $stable(tach_data); endproperty
  a_t_hold: assert property (p_t_hold) else $error("tach word not held");
endmodule : tpm_chk

bind tpm_top tpm_chk i_chk (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acq_run, .tach_valid, .tach_ready, .tach_data);

/* tpm_asm_model.sv */
// input stream assembler model: offers a/d samples and collects tach words
// assumes the bench raises want to ask for samples and reads got directly
`timescale 1ns/1ps

module tpm_asm_model (
  input  wire logic        clk,
  input  wire logic        acq_run,
  input  wire logic [15:0] want,
  input  wire logic [7:0]  gap,
  input  wire logic        stall,
  input  wire logic        smp_ready,
  output logic             smp_valid,
  output logic [15:0]      taken,
  input  wire logic        tach_valid,
  output logic             tach_ready,
  input  wire logic [31:0] tach_data
);
  logic [31:0] got[$];
  logic [7:0]  wait_c = 8'h0;
  logic        s_hs, t_hs;
  logic [31:0] t_word;

  initial
  begin
    smp_valid = 1'b0;
    tach_ready = 1'b0;
    taken = 16'h0;
  end

  // sample handshakes half a cycle early so the edge never races the dut
  always @(negedge clk)
  begin
    s_hs = smp_valid && smp_ready && acq_run;
    t_hs = tach_valid && tach_ready;
    t_word = tach_data;
  end

  // a gap above 0 leaves gap+1 idle clocks between samples; gap 0 runs them back to back
  always @(posedge clk)
  begin
    tach_ready <= !stall;
    if (t_hs) got.push_back(t_word);
    if (s_hs)
    begin
      taken <= taken + 16'h1;
      smp_valid <= (gap == 8'h0) && (taken + 16'h1 != want);
      wait_c <= gap;
    end
    else if (!smp_valid && taken != want)
    begin
      if (wait_c == 8'h0) smp_valid <= 1'b1;
      else wait_c <= wait_c - 8'h1;
    end
  end
endmodule : tpm_asm_model

/* tb_top.sv */
// testbench for tach period measure: registers, period counts, staleness, delay, fifo
// assumes the checker bind and the assembler model are compiled with the design
`timescale 1ns/1ps

module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, tach_in = 1'b0, acq_run = 1'b0, stall = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, gap = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, tach_data, s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        smp_valid, smp_ready, tach_valid, tach_ready;
  logic [15:0] want = 16'h0, taken;
  int          n_errors = 0, num_checks = 0;

  tpm_top i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tach_in, .acq_run, .smp_valid, .smp_ready,
    .tach_valid, .tach_ready, .tach_data);
  tpm_asm_model i_asm (.clk, .acq_run, .want, .gap, .stall, .smp_ready, .smp_valid, .taken,
    .tach_valid, .tach_ready, .tach_data);

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // handshakes are judged on values seen at the falling edge, i.e. those the rising edge takes; ready stays up
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_hs, w_hs, b_hs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b_hs && n < 100);
    if (!b_hs) n_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_hs, r_hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      n++;
    end while (!r_hs && n < 100);
    if (!r_hs) n_errors++;
  endtask : axi_rd

  // ask the assembler for k more samples and wait until all are taken
  task automatic take(input int k);
    int n;
    want <= want + k[15:0];
    @(posedge clk);
    for (n = 0; n < 3000 && taken != want; n++) @(posedge clk);
    if (taken != want) n_errors++;
  endtask : take

  task automatic wait_got(input int k);
    int n;
    for (n = 0; n < 300 && i_asm.got.size() < k; n++) @(posedge clk);
    if (i_asm.got.size() < k) n_errors++;
  endtask : wait_got

  // one tach pulse: high for hi clocks, period per clocks
  task automatic pulse(input int per, input int hi);
    tach_in <= 1'b1;
    repeat (hi) @(posedge clk);
    tach_in <= 1'b0;
    repeat (per - hi) @(posedge clk);
  endtask : pulse

  // stop and restart the input operation, dropping collected words
  task automatic restart;
    acq_run <= 1'b0;
    repeat (2) @(posedge clk);
    acq_run <= 1'b1;
    i_asm.got.delete();
  endtask : restart

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    axi_rd(tpm_pkg::REG_CTRL, rd, rs);
    chk("ctrl reset", tpm_pkg::CTRL_RST, rd);
    axi_rd(tpm_pkg::REG_DELAY, rd, rs);
    chk("delay reset", 32'h0000_0006, rd);
    axi_wr(tpm_pkg::REG_CHMASK, 32'h0000_0100, rs);
    axi_rd(tpm_pkg::REG_CHMASK, rd, rs);
    chk("chmask", 32'h0000_0100, rd);
    axi_wr(8'h40, 32'hFFFF_FFFF, rs);
    chk("hole write resp", {30'h0, tpm_pkg::RESP_SLVERR}, {30'h0, rs});
    axi_rd(8'h40, rd, rs);
    chk("hole read resp", {30'h0, tpm_pkg::RESP_SLVERR}, {30'h0, rs});
    chk("hole read data", 32'h0, rd);
    axi_wr(tpm_pkg::REG_COUNT, 32'h1234_5678, rs);
    chk("ro write resp", {30'h0, tpm_pkg::RESP_OKAY}, {30'h0, rs});
  endtask : t_regs

  task automatic t_delay;
    axi_wr(tpm_pkg::REG_DELAY, 32'h0000_0002, rs);
    gap <= 8'h3;
    take(2);
    repeat (10) @(posedge clk);
    chk("held by delay", 32'h0, 32'(i_asm.got.size()));
    take(1);
    wait_got(1);
    chk("before first latch", 32'h8000_0000, i_asm.got[0]);
    axi_wr(tpm_pkg::REG_DELAY, 32'h0, rs);
    restart();
  endtask : t_delay

  task automatic t_period;
    int fresh, bad, adj;
    logic [31:0] w, p;
    fresh = 0;
    bad = 0;
    adj = 0;
    p = 32'h0;
    gap <= 8'h9;
    want <= want + 16'd24;
    repeat (5) pulse(40, 20);
    take(0);
    wait_got(24);
    foreach (i_asm.got[i])
    begin
      w = i_asm.got[i];
      fresh += int'(w === 32'h29);
      adj += int'(w === 32'h29 && p === 32'h29);
      bad += int'(!(w === 32'h8000_0000 || w === 32'h29 || w === 32'h8000_0029));
      p = w;
    end
    chk("fresh words", 32'd4, 32'(fresh));
    chk("odd words", 32'd0, 32'(bad));
    chk("fresh twice", 32'd0, 32'(adj));
    chk("repeat", 32'h8000_0029, i_asm.got[$]);
  endtask : t_period

  task automatic t_last;
    acq_run <= 1'b0;
    axi_wr(tpm_pkg::REG_CTRL, 32'h0000_0006, rs);
    restart();
    take(1);
    wait_got(1);
    chk("cleared latch", 32'h8000_0000, i_asm.got[0]);
    pulse(20, 2);
    pulse(20, 2);
    pulse(30, 10);
    pulse(20, 2);
    take(2);
    wait_got(3);
    chk("newest falling", 32'h0000_0017, i_asm.got[1]);
    chk("stale repeat", 32'h8000_0017, i_asm.got[2]);
    axi_rd(tpm_pkg::REG_COUNT, rd, rs);
    chk("count reg", 32'h0000_0017, rd);
  endtask : t_last

  task automatic t_noflag;
    axi_wr(tpm_pkg::REG_CTRL, 32'h0000_0002, rs);
    take(2);
    wait_got(5);
    chk("no flag a", 32'h0000_0017, i_asm.got[3]);
    chk("no flag b", 32'h0000_0017, i_asm.got[4]);
    axi_wr(tpm_pkg::REG_CHMASK, 32'h0, rs);
    take(3);
    repeat (10) @(posedge clk);
    chk("masked", 32'd5, 32'(i_asm.got.size()));
    axi_wr(tpm_pkg::REG_CHMASK, 32'h0000_0100, rs);
  endtask : t_noflag

  // fill the fifo with the consumer stalled, then drain it
  task automatic t_fill;
    int n, g0, k0;
    g0 = i_asm.got.size();
    k0 = int'(taken);
    stall <= 1'b1;
    gap <= 8'h0;
    want <= want + 16'd40;
    for (n = 0; n < 200 && smp_ready !== 1'b0; n++) @(negedge clk);
    chk("full refuses", 32'h0, {31'h0, smp_ready});
    @(posedge clk);
    chk("depth", 32'h1, {31'h0, (int'(taken) - k0 >= 32) && (int'(taken) - k0 <= 34)});
    want <= taken + 16'h1;
    stall <= 1'b0;
    @(posedge clk);
    wait_got(g0 + int'(want) - k0);
    @(negedge clk);
    chk("all words", 32'(g0 + int'(want) - k0), 32'(i_asm.got.size()));
    chk("drained", 32'h0, {31'h0, tach_valid});
    chk("word", 32'h0000_0017, i_asm.got[$]);
    @(posedge clk);
  endtask : t_fill

  ////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    acq_run <= 1'b1;
    t_delay();
    t_period();
    t_last();
    t_noflag();
    t_fill();
    report_and_stop();
  end

  // the whole run needs well under a thousand clocks
  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_top
